// File: rtl/acs_pkg.sv
package acs_pkg;

  // ****************************************************************
  // Command word layout
  // ****************************************************************
  localparam int CMD_W       = 16;
  localparam int CMD_DEV_BIT = 15;
  localparam int CMD_RW_BIT  = 14;
  localparam int CMD_SYS_BIT = 13;
  localparam int CMD_SSH_BIT = 12;
  localparam int CMD_SSL_BIT = 11;
  localparam int CMD_CODE_HI = 8;
  localparam int CMD_CODE_LO = 1;

  // Subsystem codes, write flag low
  localparam logic [7:0] CODE_ABORT = 8'h10;
  localparam logic [7:0] CODE_END   = 8'h12;
  localparam logic [7:0] CODE_CLEAR = 8'h13;
  // Subsystem codes, write flag high
  localparam logic [7:0] CODE_SS    = 8'h00;
  localparam logic [7:0] CODE_SC    = 8'h01;
  localparam logic [7:0] CODE_MM    = 8'h02;
  localparam logic [7:0] CODE_MC    = 8'h03;
  localparam logic [7:0] CODE_MS    = 8'h04;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_MASK      = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_DATA_BASE = 8'h20;
  localparam int         CTRL_SYNC_BIT = 0;
  localparam int         CTRL_CHAN_LO  = 4;
  localparam logic       SYNC_EN_RST   = 1'b0;
  localparam logic [2:0] SEL_CHAN_RST  = 3'h0;
  localparam logic [7:0] MASK_RST      = 8'h00;

  // ****************************************************************
  // Channels and synchronisers
  // ****************************************************************
  localparam int NCH         = 8;
  localparam int CH_W        = 3;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_SYNC, ST_CONVERT, ST_RESTART, ST_WAIT_TRIG} acs_state_t;
  typedef enum logic [2:0] {MD_NONE, MD_SS, MD_SC, MD_MM, MD_MC, MD_MS} acs_mode_t;

endpackage

// File: rtl/acs_result_mem.sv
`timescale 1ns/1ps
`default_nettype none

module acs_result_mem
  import acs_pkg::*;
#(
  parameter int DW = 24
)(
  input  wire logic            core_clk_i,
  input  wire logic            nrst_i,
  input  wire logic            clear_i,
  input  wire logic            wr_i,
  input  wire logic [CH_W-1:0] waddr_i,
  input  wire logic [DW-1:0]   wdata_i,
  input  wire logic [CH_W-1:0] raddr_i,
  output logic      [DW-1:0]   rdata_o
);

  typedef struct packed {
    logic [NCH-1:0][DW-1:0] mem;
    logic [DW-1:0]          rdata;
  } acs_mem_t;

  acs_mem_t s_reg;
  acs_mem_t s_next;

  // Clear first, then the write, so a result landing in the clear cycle survives
  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = s_reg.mem[raddr_i];
    if (clear_i)
    begin
      s_next.mem = '0;
    end
    if (wr_i)
    begin
      s_next.mem[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;

endmodule

`default_nettype wire

// File: rtl/acs_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none

module acs_spi_rx
  import acs_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             spi_sclk_i,
  input  wire logic             spi_cs_n_i,
  input  wire logic             spi_mosi_i,
  output logic      [CMD_W-1:0] cmd_word_o,
  output logic                  cmd_valid_o
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] sclk_sy;
    logic [SYNC_STAGES-1:0] cs_sy;
    logic [SYNC_STAGES-1:0] mosi_sy;
    logic                   sclk_f;
    logic                   cs_f;
    logic                   mosi_f;
    logic [CMD_W-1:0]       shift;
    logic [4:0]             cnt;
    logic [CMD_W-1:0]       word;
    logic                   valid;
  } acs_spi_t;

  acs_spi_t s_reg;
  acs_spi_t s_next;
  logic     sclk_rise;

  // ****************************************************************
  // Pin filtering and word assembly
  // ****************************************************************
  // A pin level is taken only when stages two and three agree
  always_comb
  begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    s_next.sclk_sy = {s_reg.sclk_sy[1:0], spi_sclk_i};
    s_next.cs_sy = {s_reg.cs_sy[1:0], spi_cs_n_i};
    s_next.mosi_sy = {s_reg.mosi_sy[1:0], spi_mosi_i};
    if (s_reg.sclk_sy[1] == s_reg.sclk_sy[2])
    begin
      s_next.sclk_f = s_reg.sclk_sy[2];
    end
    if (s_reg.cs_sy[1] == s_reg.cs_sy[2])
    begin
      s_next.cs_f = s_reg.cs_sy[2];
    end
    if (s_reg.mosi_sy[1] == s_reg.mosi_sy[2])
    begin
      s_next.mosi_f = s_reg.mosi_sy[2];
    end
    sclk_rise = s_next.sclk_f & ~s_reg.sclk_f;
    if (s_next.cs_f)
    begin
      s_next.cnt = 5'h00;
    end
    else if (sclk_rise)
    begin
      // Mode 0, MSB first; the sixteenth rising edge ends the word
      s_next.shift = {s_reg.shift[CMD_W-2:0], s_next.mosi_f};
      if (s_reg.cnt == 5'(CMD_W - 1))
      begin
        s_next.word = s_next.shift;
        s_next.valid = 1'b1;
        s_next.cnt = 5'h00;
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 5'h01;
      end
    end
  end

  // Chip select idles high out of reset
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_reg <= '0;
      s_reg.cs_sy <= '1;
      s_reg.cs_f <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign cmd_word_o  = s_reg.word;
  assign cmd_valid_o = s_reg.valid;

endmodule

`default_nettype wire

// File: rtl/acs_sequencer.sv
// Notes on behaviour
// RULE_01 - Sixteen-bit commands, subsystem select bits zero
// RULE_02 - Stop-at-end: finish, keep result, then halt
// RULE_03 - Clear-data wipes every stored channel result
// RULE_04 - Single-shot starts on sync or command
// RULE_05 - Continuous repeats until abort or stop
// RULE_06 - Autonomous steps enabled channels, lowest first
// RULE_07 - Sync starts only first autonomous conversion
// RULE_08 - Early sync or abort restarts at first
// RULE_09 - Loop mode wraps after last enabled channel
// RULE_10 - Host repeats host-driven command per channel
// RULE_11 - Sync rise converts pointed channel, host-driven
// RULE_12 - Host-driven advances pointer, then waits trigger
// RULE_13 - Host-driven pointer wraps to lowest enabled
// RULE_14 - Stop or abort leaves host-driven mode
// RULE_15 - Host-driven early sync keeps same channel
// RULE_16 - Empty channel mask starts no conversion; single-shot and continuous commands still convert sel_chan
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer
  import acs_pkg::*;
#(
  parameter int         DW       = 24,
  parameter logic       DEV_ADDR = 1'b0
)(
  input  wire logic            core_clk_i,
  input  wire logic            nrst_i,
  input  wire logic            spi_sclk_i,
  input  wire logic            spi_cs_n_i,
  input  wire logic            spi_mosi_i,
  input  wire logic            sync_i,
  input  wire logic            conv_done_i,
  input  wire logic [DW-1:0]   conv_data_i,
  output logic                 conv_start_o,
  output logic                 conv_abort_o,
  output logic      [CH_W-1:0] conv_chan_o,
  output logic                 busy_o,
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic [31:0]     reg_wdata_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  output logic      [31:0]     reg_rdata_o
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync_sy;
    logic                   sync_f;
    logic                   sync_en;
    logic [CH_W-1:0]        sel_chan;
    logic [NCH-1:0]         mask;
    acs_state_t             state;
    acs_mode_t              mode;
    logic [CH_W-1:0]        ptr;
    logic [CH_W-1:0]        chan;
    logic                   stop;
    logic                   start;
    logic                   abort;
    logic                   clear;
    logic [31:0]            rdata;
    logic                   rd_mem;
  } acs_seq_t;

  acs_seq_t         s_reg;
  acs_seq_t         s_next;
  logic [CMD_W-1:0] cmd_word;
  logic             cmd_valid;
  logic             cmd_ok;
  logic             cmd_rw;
  logic [7:0]       cmd_code;
  logic             sync_rise;
  logic [CH_W:0]    first_c;
  logic [CH_W:0]    nxt_c;
  logic             mem_wr_c;
  logic [DW-1:0]    mem_rdata;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Lowest enabled channel above from (or at it when incl); top bit is found
  function automatic logic [CH_W:0] next_en(input logic [NCH-1:0] mask,
                                            input logic [CH_W-1:0] from,
                                            input logic            incl);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (mask[i] && ((i > int'(from)) || (incl && (i == int'(from)))))
      begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction

  // RULE_01 subsystem command match
  function automatic logic is_sub_cmd(input logic [CMD_W-1:0] w);
    return (w[CMD_DEV_BIT] == DEV_ADDR) && w[CMD_SYS_BIT] &&
           !w[CMD_SSH_BIT] && !w[CMD_SSL_BIT];
  endfunction

  acs_spi_rx u_spi
  (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .spi_sclk_i  (spi_sclk_i),
    .spi_cs_n_i  (spi_cs_n_i),
    .spi_mosi_i  (spi_mosi_i),
    .cmd_word_o  (cmd_word),
    .cmd_valid_o (cmd_valid)
  );

  acs_result_mem #(.DW(DW)) u_mem
  (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .clear_i    (s_reg.clear),
    .wr_i       (mem_wr_c),
    .waddr_i    (s_reg.chan),
    .wdata_i    (conv_data_i),
    .raddr_i    (reg_addr_i[4:2]),
    .rdata_o    (mem_rdata)
  );

  // Decode fields; bit zero and the channel bits are don't-care
  assign cmd_ok   = cmd_valid && is_sub_cmd(cmd_word);
  assign cmd_rw   = cmd_word[CMD_RW_BIT];
  assign cmd_code = cmd_word[CMD_CODE_HI:CMD_CODE_LO];
  assign first_c  = next_en(s_reg.mask, '0, 1'b1);
  assign nxt_c    = next_en(s_reg.mask, s_reg.ptr, 1'b0);
  assign mem_wr_c = (s_reg.state == ST_CONVERT) && conv_done_i;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Order: sequence progress first, then commands, so an abort has the last say
  always_comb
  begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.abort = 1'b0;
    s_next.clear = 1'b0;
    s_next.rd_mem = 1'b0;
    s_next.rdata = '0;
    s_next.sync_sy = {s_reg.sync_sy[1:0], sync_i};
    if (s_reg.sync_sy[1] == s_reg.sync_sy[2])
    begin
      s_next.sync_f = s_reg.sync_sy[2];
    end
    sync_rise = s_next.sync_f & ~s_reg.sync_f;

    // Register writes
    if (reg_wr_i && (reg_addr_i == REG_CTRL))
    begin
      s_next.sync_en = reg_wdata_i[CTRL_SYNC_BIT];
      s_next.sel_chan = reg_wdata_i[CTRL_CHAN_LO +: CH_W];
    end
    if (reg_wr_i && (reg_addr_i == REG_MASK))
    begin
      s_next.mask = reg_wdata_i[NCH-1:0];
    end

    // Register reads, data one cycle later
    if (reg_rd_i)
    begin
      if (reg_addr_i == REG_CTRL)
      begin
        s_next.rdata[CTRL_SYNC_BIT] = s_reg.sync_en;
        s_next.rdata[CTRL_CHAN_LO +: CH_W] = s_reg.sel_chan;
      end
      else if (reg_addr_i == REG_MASK)
      begin
        s_next.rdata[NCH-1:0] = s_reg.mask;
      end
      else if (reg_addr_i == REG_STATUS)
      begin
        s_next.rdata[10:0] = {s_reg.stop, s_reg.mode, s_reg.state, s_reg.ptr, busy_o};
      end
      else if ((reg_addr_i[7:5] == REG_DATA_BASE[7:5]) && (reg_addr_i[1:0] == 2'h0))
      begin
        s_next.rd_mem = 1'b1;
      end
    end

    case (s_reg.state)
      ST_IDLE:
      begin
        s_next.mode = MD_NONE;
      end
      ST_WAIT_SYNC:
      begin
        // RULE_04 sync launches first
        if (sync_rise)
        begin
          s_next.start = 1'b1;
          s_next.state = ST_CONVERT;
        end
      end
      ST_WAIT_TRIG:
      begin
        // RULE_11 sync converts pointer
        if (s_reg.sync_en && sync_rise)
        begin
          s_next.chan = s_reg.ptr;
          s_next.start = 1'b1;
          s_next.state = ST_CONVERT;
        end
      end
      ST_RESTART:
      begin
        s_next.chan = s_reg.ptr;
        s_next.start = 1'b1;
        s_next.state = ST_CONVERT;
      end
      ST_CONVERT:
      begin
        if (conv_done_i)
        begin
          // RULE_02 result kept, halt
          if (s_reg.stop)
          begin
            s_next.state = ST_IDLE;
            s_next.mode = MD_NONE;
            s_next.stop = 1'b0;
          end
          else
          begin
            case (s_reg.mode)
              MD_SC:
              begin
                // RULE_05 convert again
                s_next.start = 1'b1;
              end
              MD_MM:
              begin
                // RULE_06 RULE_07 next channel unprompted
                if (nxt_c[CH_W])
                begin
                  s_next.ptr = nxt_c[CH_W-1:0];
                  s_next.chan = nxt_c[CH_W-1:0];
                  s_next.start = 1'b1;
                end
                else
                begin
                  s_next.state = ST_IDLE;
                  s_next.mode = MD_NONE;
                end
              end
              MD_MC:
              begin
                // RULE_09 wrap and loop
                if (nxt_c[CH_W] || first_c[CH_W])
                begin
                  s_next.ptr = nxt_c[CH_W] ? nxt_c[CH_W-1:0] : first_c[CH_W-1:0];
                  s_next.chan = s_next.ptr;
                  s_next.start = 1'b1;
                end
                else
                begin
                  s_next.state = ST_IDLE;
                  s_next.mode = MD_NONE;
                end
              end
              MD_MS:
              begin
                // RULE_12 RULE_13 advance, wrap, wait
                s_next.ptr = nxt_c[CH_W] ? nxt_c[CH_W-1:0] : first_c[CH_W-1:0];
                s_next.state = ST_WAIT_TRIG;
              end
              default:
              begin
                s_next.state = ST_IDLE;
                s_next.mode = MD_NONE;
              end
            endcase
          end
        end
        else if (sync_rise && (s_reg.mode == MD_MS))
        begin
          // RULE_15 abort, same channel
          s_next.abort = 1'b1;
          s_next.state = ST_RESTART;
        end
        else if (sync_rise && ((s_reg.mode == MD_MM) || (s_reg.mode == MD_MC)))
        begin
          // RULE_08 abort, back to first
          s_next.abort = 1'b1;
          s_next.ptr = first_c[CH_W-1:0];
          s_next.state = first_c[CH_W] ? ST_RESTART : ST_IDLE;
        end
      end
      default:
      begin
        s_next.state = ST_IDLE;
      end
    endcase

    if (cmd_ok && !cmd_rw)
    begin
      if (cmd_code == CODE_ABORT)
      begin
        // RULE_08 RULE_14 abort exits mode
        s_next.abort = (s_reg.state == ST_CONVERT);
        s_next.start = 1'b0;
        s_next.ptr = first_c[CH_W-1:0];
        s_next.state = ST_IDLE;
        s_next.mode = MD_NONE;
        s_next.stop = 1'b0;
      end
      else if (cmd_code == CODE_END)
      begin
        // RULE_02 RULE_14 halt when current ends
        if ((s_next.state == ST_CONVERT) || (s_next.state == ST_RESTART))
        begin
          s_next.stop = 1'b1;
        end
        else
        begin
          s_next.state = ST_IDLE;
          s_next.mode = MD_NONE;
        end
      end
      else if (cmd_code == CODE_CLEAR)
      begin
        // RULE_03 wipe results
        s_next.clear = 1'b1;
      end
    end
    else if (cmd_ok && (s_next.state != ST_CONVERT) && (s_next.state != ST_RESTART))
    begin
      if ((cmd_code == CODE_SS) || (cmd_code == CODE_SC))
      begin
        // RULE_04 RULE_05 sync or command edge
        s_next.mode = (cmd_code == CODE_SS) ? MD_SS : MD_SC;
        s_next.chan = s_reg.sel_chan;
        s_next.stop = 1'b0;
        s_next.state = s_reg.sync_en ? ST_WAIT_SYNC : ST_CONVERT;
        s_next.start = !s_reg.sync_en;
      end
      else if ((cmd_code == CODE_MM) || (cmd_code == CODE_MC))
      begin
        // RULE_16 empty mask ignored
        if (first_c[CH_W])
        begin
          s_next.mode = (cmd_code == CODE_MM) ? MD_MM : MD_MC;
          s_next.ptr = first_c[CH_W-1:0];
          s_next.chan = first_c[CH_W-1:0];
          s_next.stop = 1'b0;
          s_next.state = s_reg.sync_en ? ST_WAIT_SYNC : ST_CONVERT;
          s_next.start = !s_reg.sync_en;
        end
      end
      else if (cmd_code == CODE_MS)
      begin
        if ((s_reg.mode == MD_MS) && (s_next.state == ST_WAIT_TRIG))
        begin
          // RULE_10 repeat converts next channel
          if (!s_reg.sync_en)
          begin
            s_next.chan = s_next.ptr;
            s_next.start = 1'b1;
            s_next.state = ST_CONVERT;
          end
        end
        else if (first_c[CH_W])
        begin
          // RULE_16 empty mask ignored
          s_next.mode = MD_MS;
          s_next.ptr = first_c[CH_W-1:0];
          s_next.chan = first_c[CH_W-1:0];
          s_next.stop = 1'b0;
          s_next.state = s_reg.sync_en ? ST_WAIT_TRIG : ST_CONVERT;
          s_next.start = !s_reg.sync_en;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_reg <= '0;
      s_reg.sync_en <= SYNC_EN_RST;
      s_reg.sel_chan <= SEL_CHAN_RST;
      s_reg.mask <= MASK_RST;
      s_reg.state <= ST_IDLE;
      s_reg.mode <= MD_NONE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Memory data come straight from its own output register
  assign reg_rdata_o  = s_reg.rd_mem ? {{(32 - DW){1'b0}}, mem_rdata} : s_reg.rdata;
  assign conv_start_o = s_reg.start;
  assign conv_abort_o = s_reg.abort;
  assign conv_chan_o  = s_reg.chan;
  assign busy_o       = (s_reg.state != ST_IDLE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_stop_halt: assert property ( // RULE_02
    (s_reg.state == ST_CONVERT) && s_reg.stop && conv_done_i && !cmd_valid
    |=> (s_reg.state == ST_IDLE) && !conv_start_o) else $error("stop did not halt");
  chk_clear_data: assert property ( // RULE_03
    cmd_ok && !cmd_rw && (cmd_code == CODE_CLEAR) |=> s_reg.clear) else $error("no clear");
  chk_ss_start: assert property ( // RULE_04
    cmd_ok && cmd_rw && (cmd_code == CODE_SS) && !s_reg.sync_en && (s_reg.state == ST_IDLE)
    |=> conv_start_o && (conv_chan_o == $past(s_reg.sel_chan))) else $error("ss no start");
  chk_sc_repeat: assert property ( // RULE_05
    (s_reg.state == ST_CONVERT) && (s_reg.mode == MD_SC) && conv_done_i && !s_reg.stop
    && !cmd_valid |=> conv_start_o) else $error("sc did not repeat");
  chk_mm_ascend: assert property ( // RULE_06
    (s_reg.state == ST_CONVERT) && (s_reg.mode == MD_MM) && conv_done_i && !s_reg.stop
    && nxt_c[CH_W] && !cmd_valid |=> conv_start_o && (conv_chan_o > $past(s_reg.chan)))
    else $error("mm did not step up");
  chk_mm_sync: assert property ( // RULE_08
    (s_reg.state == ST_CONVERT) && (s_reg.mode == MD_MM) && sync_rise && !conv_done_i
    && first_c[CH_W] && !cmd_valid |=> conv_abort_o ##1
    (conv_start_o && (conv_chan_o == $past(first_c[CH_W-1:0], 2))))
    else $error("mm sync restart wrong");
  chk_ms_wait: assert property ( // RULE_12
    (s_reg.state == ST_CONVERT) && (s_reg.mode == MD_MS) && conv_done_i && !s_reg.stop
    && !cmd_valid |=> (s_reg.state == ST_WAIT_TRIG) && !conv_start_o)
    else $error("ms did not wait");
  chk_ms_hold: assert property ( // RULE_15
    (s_reg.state == ST_CONVERT) && (s_reg.mode == MD_MS) && sync_rise && !conv_done_i
    && !cmd_valid |=> conv_abort_o ##1 (conv_start_o && (conv_chan_o == $past(s_reg.chan, 2))))
    else $error("ms sync moved channel");
  chk_ms_exit: assert property ( // RULE_14
    cmd_ok && !cmd_rw && (cmd_code == CODE_ABORT) |=> (s_reg.state == ST_IDLE))
    else $error("abort did not exit");
  chk_zero_mask: assert property ( // RULE_16
    cmd_ok && cmd_rw && (s_reg.mask == '0) && (s_reg.state == ST_IDLE) && (cmd_code != CODE_SS)
    && (cmd_code != CODE_SC) |=> !conv_start_o && (s_reg.state == ST_IDLE))
    else $error("empty mask started");

endmodule

`default_nettype wire

// File: bench/acs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side: shifts one word out in mode 0, MSB first, 125 ns bit period
module acs_host_model (
  input  wire logic [15:0] word_i,
  input  wire logic        go_i,
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic             mosi_o,
  output logic             done_o
);
  initial {sclk_o, cs_n_o, mosi_o, done_o} = 4'h6;
  always @(posedge go_i)
  begin
    done_o = 1'h0;
    cs_n_o = 1'h0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi_o = word_i[i];
      #62.5 sclk_o = 1'h1;
      #62.5 sclk_o = 1'h0;
    end
    #62.5 cs_n_o = 1'h1;
    // Released line flips so a stale bit never reads as valid
    mosi_o = ~mosi_o;
    done_o = 1'h1;
  end
endmodule
`default_nettype wire

// File: bench/acs_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer_test;
  import acs_pkg::*;
  logic        clk = 0, nrst = 0, sync = 0, done = 0, wr = 0, rd = 0, go = 0;
  logic [23:0] dat = 24'h0;
  logic [7:0]  ra = 8'h0;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [15:0] word = 16'h0;
  logic        sclk, cs_n, mosi, hdone, start, abort, busy;
  logic [2:0]  chan;
  logic [2:0]  seq[$];
  int          num_errors = 0, checks_done = 0, cnt = 0, ndone = 0, nabort = 0, b;

  always #5 clk = ~clk;

  acs_sequencer dut_u (.core_clk_i(clk), .nrst_i(nrst), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .sync_i(sync), .conv_done_i(done),
    .conv_data_i(dat), .conv_start_o(start), .conv_abort_o(abort),
    .conv_chan_o(chan), .busy_o(busy), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat));
  acs_host_model host_u (.word_i(word), .go_i(go), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi), .done_o(hdone));

  // Converter stand-in: 20 cycles a conversion, result tagged by channel
  always @(posedge clk)
  begin
    done <= 0;
    if (start)
    begin
      seq.push_back(chan);
      cnt <= 20;
    end
    else if (abort)
    begin
      nabort <= nabort + 1;
      cnt <= 0;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        done <= 1;
        dat <= {21'h0A5A5, chan};
        ndone <= ndone + 1;
      end
    end
  end

  // command layout, device address bit zero
  function automatic logic [15:0] cmd(input logic rw, input logic [7:0] code);
    return {1'h0, rw, 1'h1, 4'h0, code, 1'h0};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask

  task reg_rd(input logic [7:0] a);
    @(posedge clk);
    ra <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 v = rdat;
  endtask

  // Sends a word, then gives the filter time to hand it on
  task send(input logic [15:0] w);
    @(posedge clk);
    word <= w;
    go <= 1;
    @(posedge clk);
    go <= 0;
    for (int i = 0; i < 400 && hdone !== 1; i++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask

  task idle();
    for (int i = 0; i < 400 && busy !== 0; i++) @(posedge clk);
  endtask

  task pulse(input int n);
    sync <= 1;
    repeat (4) @(posedge clk);
    sync <= 0;
    repeat (n) @(posedge clk);
  endtask

  task t_auto(input logic [7:0] m);
    int k;
    k = 0;
    reg_wr(REG_MASK, {24'h0, m});
    seq.delete();
    send(cmd(1, CODE_MM));
    idle();
    chk(seq.size(), $countones(m));
    for (int c = 0; c < 8; c++)
      if (m[c] && k < seq.size())
      begin
        chk(seq[k], c);
        k++;
      end
  endtask

  task report_and_stop();
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1;
    repeat (6) @(posedge clk);
    reg_rd(REG_MASK);
    chk(v, 0);
    reg_rd(8'hFC);
    chk(v, 0);
    reg_wr(REG_CTRL, 32'h50);
    seq.delete();
    send(cmd(1, CODE_SS));
    idle();
    chk(seq.size(), 1);
    chk(seq[0], 5);
    reg_rd(REG_DATA_BASE + 8'h14);
    chk(v, {8'h00, 21'h0A5A5, 3'h5});
    t_auto(8'hA4);
    t_auto(8'h00);
    t_auto(8'hFF);
    send(cmd(0, CODE_CLEAR));
    for (int n = 0; n < 8; n++)
    begin
      reg_rd(REG_DATA_BASE + 8'(4 * n));
      chk(v, 0);
    end
    reg_wr(REG_MASK, 32'h81);
    seq.delete();
    b = ndone;
    send(cmd(1, CODE_MC));
    send(cmd(0, CODE_END));
    idle();
    chk(seq[1], 7);
    chk(seq[2], 0);
    chk(ndone - b, seq.size());
    reg_wr(REG_CTRL, 32'h30);
    seq.delete();
    b = nabort;
    send(cmd(1, CODE_SC));
    send(cmd(0, CODE_ABORT));
    chk(busy, 0);
    chk(nabort - b, 1);
    chk(seq.size() > 4, 1);
    chk(seq[$], 3);
    reg_wr(REG_MASK, 32'h06);
    seq.delete();
    for (int p = 0; p < 3; p++)
    begin
      send(cmd(1, CODE_MS));
      repeat (30) @(posedge clk);
    end
    chk({seq[0], seq[1], seq[2]}, 9'h051);
    chk(busy, 1);
    send(cmd(0, CODE_END));
    chk(busy, 0);
    reg_wr(REG_CTRL, 32'h1);
    reg_wr(REG_MASK, 32'h06);
    seq.delete();
    b = nabort;
    send(cmd(1, CODE_MM));
    chk(seq.size(), 0);
    pulse(10);
    pulse(0);
    idle();
    chk(nabort - b, 1);
    chk({seq[0], seq[1], seq[2]}, 9'h04A);
    seq.delete();
    send(cmd(1, CODE_MS));
    for (int p = 0; p < 3; p++) pulse(40);
    chk({seq[0], seq[1], seq[2]}, 9'h051);
    send(cmd(0, CODE_END));
    chk(busy, 0);
    seq.delete();
    b = nabort;
    send(cmd(1, CODE_MS));
    pulse(40);
    pulse(10);
    pulse(40);
    chk(nabort - b, 1);
    chk({seq[0], seq[1], seq[2]}, 9'h052);
    send(cmd(0, CODE_ABORT));
    chk(busy, 0);
    report_and_stop();
  end

  // Watchdog, about twice the expected run length
  initial
  begin
    #100us;
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
